// ### verilog/spi_ctrl.sv
// Serial port control, status, clock generator and shifter.
// Assumes a classic Wishbone master and pins resolved by the surroundings.
`timescale 1ns/1ns
module spi_ctrl
   import spi_ctrl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        halt_i,
   input  wire logic        global_mask_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   output logic             wake_o,
   output logic             pins_owned_o,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   input  wire logic        select_n_i
);
   import spi_ctrl_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LEAD  = 2'b01,
      ST_TRAIL = 2'b10
   } xfer_state_t;

   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic sel_n_s;
   logic run;

   // Halt freezes every register of the port
   assign run = ce_i & ~halt_i;

   pin_sync u_sck  (.clk_i(clk_i), .rst_i(rst_i), .ce_i(run), .rst_val_i(1'b1), .pin_i(sck_i),      .sync_o(sck_s));
   pin_sync u_mosi (.clk_i(clk_i), .rst_i(rst_i), .ce_i(run), .rst_val_i(1'b1), .pin_i(mosi_i),     .sync_o(mosi_s));
   pin_sync u_miso (.clk_i(clk_i), .rst_i(rst_i), .ce_i(run), .rst_val_i(1'b1), .pin_i(miso_i),     .sync_o(miso_s));
   pin_sync u_sel  (.clk_i(clk_i), .rst_i(rst_i), .ce_i(run), .rst_val_i(1'b1), .pin_i(select_n_i), .sync_o(sel_n_s));

   logic [7:0]  ctrl_q, ctrl_d;
   logic        done_q, done_d;
   logic        clash_q, clash_d;
   logic        fault_q, fault_d;
   logic        done_armed_q, done_armed_d;
   logic        fault_armed_q, fault_armed_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  rxbuf_q, rxbuf_d;
   logic [3:0]  bits_q, bits_d;
   logic [6:0]  div_q, div_d;
   logic        sck_q, sck_d;
   logic        sck_prev_q, sck_prev_d;
   logic        out_bit_q, out_bit_d;
   logic        ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   xfer_state_t st_q, st_d;
   // Master samples return data one cycle after its capture edge: the pin
   // synchroniser delays it too much to sample on the edge at the /4 rate
   logic        cap_q, cap_d;
   logic        last_q, last_d;

   logic        req, wr, rd;
   logic        hit_data, hit_ctrl, hit_flags;
   logic        master, enabled, idle_clock_level, capture_edge_choice;
   logic [6:0]  half;
   logic        busy;
   logic        slave_edge, slave_lead, slave_trail;
   logic        fault_ev;

   assign master  = ctrl_q[ROLE_BIT];
   assign enabled = ctrl_q[OUT_EN_BIT];
   assign idle_clock_level    = ctrl_q[IDLE_BIT];
   assign capture_edge_choice    = ctrl_q[PHASE_BIT];

   assign req       = wb_cyc_i & wb_stb_i & ~ack_q & run;
   assign wr        = req & wb_we_i & wb_sel_i[0];
   assign rd        = req & ~wb_we_i;
   assign hit_data  = wb_adr_i == DATA_OFS;
   assign hit_ctrl  = wb_adr_i == CTRL_OFS;
   assign hit_flags = wb_adr_i == FLAGS_OFS;
   assign busy      = st_q != ST_IDLE;

   always_comb
   begin
      unique case ({ctrl_q[HALVER_BIT], ctrl_q[1:0]})
         3'b100:  half = HALF_DIV4;
         3'b000:  half = HALF_DIV8;
         3'b001:  half = HALF_DIV16;
         3'b110:  half = HALF_DIV32;
         3'b010:  half = HALF_DIV64;
         3'b011:  half = HALF_DIV128;
         3'b101:  half = HALF_DIV16;
         default: half = HALF_DIV128;
      endcase
   end

   // Slave clock edges, relative to idle level
   assign slave_edge  = ~master & enabled & ~sel_n_s & (sck_s != sck_prev_q);
   assign slave_lead  = slave_edge & ((sck_s ^ idle_clock_level) == 1'b1);
   assign slave_trail = slave_edge & ((sck_s ^ idle_clock_level) == 1'b0);
   assign fault_ev    = master & ~sel_n_s;

   always_comb
   begin
      ctrl_d        = ctrl_q;
      done_d        = done_q;
      clash_d       = clash_q;
      fault_d       = fault_q;
      done_armed_d  = done_armed_q;
      fault_armed_d = fault_armed_q;
      shift_d       = shift_q;
      rxbuf_d       = rxbuf_q;
      bits_d        = bits_q;
      div_d         = div_q;
      sck_d         = sck_q;
      sck_prev_d    = sck_s;
      out_bit_d     = out_bit_q;
      st_d          = st_q;
      ack_d         = req;
      rdat_d        = 32'h0000_0000;
      cap_d         = 1'b0;
      last_d        = 1'b0;

      // Status access arms the clearing sequences
      if (req && hit_flags)
      begin
         done_armed_d  = done_q;
         fault_armed_d = fault_q;
      end
      if (req && hit_data && done_armed_q)
      begin
         done_d       = 1'b0;
         clash_d      = 1'b0;
         done_armed_d = 1'b0;
      end
      if (rd && hit_data)
         rdat_d = {24'h00_0000, rxbuf_q};
      if (rd && hit_ctrl)
         rdat_d = {24'h00_0000, ctrl_q};
      if (rd && hit_flags)
         rdat_d = {24'h00_0000, done_q, clash_q, 1'b0, fault_q, 4'h0};

      if (wr && hit_ctrl)
      begin
         ctrl_d = wb_dat_i[7:0];
         if (fault_armed_q)
         begin
            fault_d       = 1'b0;
            fault_armed_d = 1'b0;
         end
         else if (fault_q)
         begin
            ctrl_d[OUT_EN_BIT] = 1'b0;
            ctrl_d[ROLE_BIT]   = 1'b0;
         end
      end

      // Data write: load shifter, collide, or drop
      if (wr && hit_data && !done_q)
      begin
         if (busy || cap_q || (!master && !sel_n_s && !capture_edge_choice))
            clash_d = 1'b1;
         else
         begin
            shift_d   = wb_dat_i[7:0];
            out_bit_d = wb_dat_i[7];
            if (master && enabled)
            begin
               st_d   = ST_LEAD;
               bits_d = 4'h0;
               div_d  = half;
            end
         end
      end

      if (cap_q)
      begin
         shift_d = {shift_q[6:0], miso_s};
         if (last_q)
         begin
            done_d  = 1'b1;
            rxbuf_d = {shift_q[6:0], miso_s};
         end
      end

      if (master && enabled && busy)
      begin
         if (div_q > 7'h01)
            div_d = div_q - 7'h01;
         else
         begin
            div_d = half;
            sck_d = ~sck_q;
            if (st_q == ST_LEAD)
            begin
               st_d = ST_TRAIL;
               if (!capture_edge_choice)
                  cap_d = 1'b1;
               else
                  out_bit_d = shift_q[7];
            end
            else
            begin
               if (capture_edge_choice)
                  cap_d = 1'b1;
               else
                  out_bit_d = shift_q[7];
               bits_d = bits_q + 4'h1;
               st_d   = ST_LEAD;
               if (bits_q == 4'(BITS_PER_XFER - 1))
               begin
                  st_d = ST_IDLE;
                  if (capture_edge_choice)
                     last_d = 1'b1;
                  else
                  begin
                     done_d  = 1'b1;
                     rxbuf_d = shift_q;
                  end
               end
            end
         end
      end
      else if (!master)
      begin
         sck_d = idle_clock_level;
         if (slave_lead)
         begin
            if (st_q == ST_IDLE)
            begin
               st_d   = ST_LEAD;
               bits_d = 4'h0;
            end
            if (!capture_edge_choice)
               shift_d = {shift_q[6:0], mosi_s};
            else
               out_bit_d = shift_q[7];
         end
         if (slave_trail && busy)
         begin
            if (capture_edge_choice)
               shift_d = {shift_q[6:0], mosi_s};
            else
               out_bit_d = shift_q[7];
            bits_d = bits_q + 4'h1;
            if (bits_q == 4'(BITS_PER_XFER - 1))
            begin
               st_d    = ST_IDLE;
               done_d  = 1'b1;
               rxbuf_d = capture_edge_choice ? {shift_q[6:0], mosi_s} : shift_q;
               // Shifter keeps the received byte for echo
            end
         end
         if (!capture_edge_choice && st_q == ST_IDLE)
            out_bit_d = shift_q[7];
      end
      if (!busy && master)
         sck_d = idle_clock_level;

      if (fault_ev)
      begin
         fault_d            = 1'b1;
         ctrl_d[OUT_EN_BIT] = 1'b0;
         ctrl_d[ROLE_BIT]   = 1'b0;
         st_d               = ST_IDLE;
      end
      if (rd && hit_data)
         rdat_d = {24'h00_0000, rxbuf_q};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q        <= CTRL_RESET;
         {done_q, clash_q, fault_q} <= FLAGS_RESET[2:0];
         done_armed_q  <= 1'b0;
         fault_armed_q <= 1'b0;
         shift_q       <= 8'h00;
         rxbuf_q       <= 8'h00;
         bits_q        <= 4'h0;
         div_q         <= 7'h00;
         sck_q         <= 1'b0;
         sck_prev_q    <= 1'b1;
         out_bit_q     <= 1'b0;
         st_q          <= ST_IDLE;
         cap_q         <= 1'b0;
         last_q        <= 1'b0;
         ack_q         <= 1'b0;
         rdat_q        <= 32'h0000_0000;
      end
      else if (run)
      begin
         ctrl_q        <= ctrl_d;
         done_q        <= done_d;
         clash_q       <= clash_d;
         fault_q       <= fault_d;
         done_armed_q  <= done_armed_d;
         fault_armed_q <= fault_armed_d;
         shift_q       <= shift_d;
         rxbuf_q       <= rxbuf_d;
         bits_q        <= bits_d;
         div_q         <= div_d;
         sck_q         <= sck_d;
         sck_prev_q    <= sck_prev_d;
         out_bit_q     <= out_bit_d;
         st_q          <= st_d;
         cap_q         <= cap_d;
         last_q        <= last_d;
         ack_q         <= ack_d;
         rdat_q        <= rdat_d;
      end
   end

   assign wb_ack_o     = ack_q;
   assign wb_dat_o     = rdat_q;
   // One shared request line for both events
   assign irq_o        = ctrl_q[IRQ_EN_BIT] & (done_q | fault_q) & ~global_mask_i;
   assign wake_o       = irq_o & ~halt_i;
   assign pins_owned_o = enabled;
   assign sck_o        = sck_q;
   assign sck_oe_o     = enabled & master;
   assign mosi_o       = out_bit_q;
   assign mosi_oe_o    = enabled & master;
   assign miso_o       = out_bit_q;
   assign miso_oe_o    = enabled & ~master & ~sel_n_s;
endmodule : spi_ctrl

// ### verilog/spi_ctrl_pkg.sv
// Constants for the byte-wide serial port control and status unit.
// Assumes a classic Wishbone register bus with 32-bit words and one clock.
package spi_ctrl_pkg;
   localparam logic [3:0] DATA_OFS  = 4'h0;
   localparam logic [3:0] CTRL_OFS  = 4'h4;
   localparam logic [3:0] FLAGS_OFS = 4'h8;
   localparam int IRQ_EN_BIT  = 7;
   localparam int OUT_EN_BIT  = 6;
   localparam int HALVER_BIT  = 5;
   localparam int ROLE_BIT    = 4;
   localparam int IDLE_BIT    = 3;
   localparam int PHASE_BIT   = 2;
   localparam int DONE_BIT    = 7;
   localparam int CLASH_BIT   = 6;
   localparam int FAULT_BIT   = 4;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam int BITS_PER_XFER = 8;
   // Half-period in CPU cycles for each divisor
   localparam logic [6:0] HALF_DIV4   = 7'h02;
   localparam logic [6:0] HALF_DIV8   = 7'h04;
   localparam logic [6:0] HALF_DIV16  = 7'h08;
   localparam logic [6:0] HALF_DIV32  = 7'h10;
   localparam logic [6:0] HALF_DIV64  = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;
endpackage : spi_ctrl_pkg

// ### verilog/pin_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ns
module pin_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic rst_val_i,
   input  wire logic pin_i,
   output logic      sync_o
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   always_comb
   begin
      meta_d = ce_i ? pin_i : meta_q;
      sync_d = ce_i ? meta_q : sync_q;
   end

   // Reset values are constant-like straps driven from a tie in the parent
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_q <= rst_val_i;
         sync_q <= rst_val_i;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;
endmodule : pin_sync

// ### verif/spi_slave_model.sv
// Behavioural far-side serial slave for the control unit bench.
// Assumes the bench selects it and gives it the same idle level and phase.
`timescale 1ns/1ns
module spi_slave_model (
   input  wire logic       sck_i,
   input  wire logic       sel_n_i,
   input  wire logic       mosi_i,
   input  wire logic       idle_clock_level_i,
   input  wire logic       capture_edge_choice_i,
   input  wire logic [7:0] load_i,
   output logic            miso_o,
   output logic [7:0]      got_o
);
   logic [7:0] sh = 8'h00;
   initial
   begin
      got_o = 8'h00;
      miso_o = 1'b0;
   end
   always @(negedge sel_n_i)
   begin
      sh = load_i;
      miso_o = load_i[7];
   end
   // Phase 0 captures on leaving idle, phase 1 on returning to idle
   always @(sck_i)
      if (!sel_n_i)
      begin
         if ((sck_i != idle_clock_level_i) != capture_edge_choice_i)
         begin
            sh = {sh[6:0], mosi_i};
            got_o = sh;
         end
         else
            miso_o = sh[7];
      end
   // Released line flips so a stale level can never pass for data
   always @(posedge sel_n_i)
      miso_o = ~miso_o;
endmodule : spi_slave_model

// ### verif/spi_ctrl_assertions.sv
// Port-level checker for the serial port control unit.
// Assumes a Wishbone master that holds its request until ack.
`timescale 1ns/1ns
module spi_ctrl_checker
   import spi_ctrl_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        halt_i,
   input wire logic        global_mask_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic        wake_o,
   input wire logic        pins_owned_o,
   input wire logic        sck_o,
   input wire logic        sck_oe_o,
   input wire logic        mosi_oe_o,
   input wire logic        miso_oe_o,
   input wire logic        select_n_i
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Select held low long enough to pass the pin synchroniser
   sequence master_sel_low_s;
      sck_oe_o && $fell(select_n_i) ##1 !select_n_i [*4];
   endsequence
   irq_gate_a: assert property (irq_o |-> !global_mask_i)
      else $error("irq raised while globally masked");
   wake_halt_a: assert property (halt_i |-> !wake_o)
      else $error("wake raised during halt");
   wake_wait_a: assert property (!halt_i |-> wake_o == irq_o)
      else $error("wake differs from irq outside halt");
   pins_reset_a: assert property ($past(rst_i) |-> !pins_owned_o)
      else $error("pins owned right after reset");
   pins_grant_a: assert property ($rose(pins_owned_o)
      |-> $past(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == CTRL_OFS))
      else $error("pins taken without a control write");
   fault_drop_a: assert property (master_sel_low_s |-> ##[0:3] !pins_owned_o && !sck_oe_o)
      else $error("master fault did not release pins");
   flags_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == FLAGS_OFS
      |-> wb_dat_o[5] == 1'b0 && wb_dat_o[3:0] == 4'h0)
      else $error("unused flag bits read nonzero");
   sck_half_a: assert property (sck_oe_o && $changed(sck_o) |=> $stable(sck_o))
      else $error("serial clock half period below two cycles");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i && !halt_i |=> wb_ack_o)
      else $error("bus request not answered next cycle");
endmodule : spi_ctrl_checker
bind spi_ctrl spi_ctrl_checker chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .halt_i(halt_i),
   .global_mask_i(global_mask_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .wake_o(wake_o),
   .pins_owned_o(pins_owned_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o),
   .miso_oe_o(miso_oe_o), .select_n_i(select_n_i));

// ### verif/tb_spi_ctrl.sv
// Self-checking bench for the serial port control unit.
// Assumes the slave model on the far side and a one-cycle bus answer.
`timescale 1ns/1ns
module tb_spi_ctrl;
   import spi_ctrl_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, halt = 1'b0, gmask = 1'b1, sel_n = 1'b1, ssel_n = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, idle_clock_level = 1'b0, capture_edge_choice = 1'b0, sck_q = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, seed = 32'h67e4;
   logic [7:0]  load = 8'h00, sgot, junk;
   logic        ack, irq, wake, owned, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, smiso;
   int          fail_count = 0, cmp_count = 0, edges = 0, gap = 0, last_gap = 0, cycles = 0;
   logic [2:0]  codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
   always #4 clk = ~clk;
   spi_ctrl dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .halt_i(halt), .global_mask_i(gmask),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .wake_o(wake), .pins_owned_o(owned),
      .sck_i(sck_oe ? sck_o : idle_clock_level), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_i(mosi_oe ? mosi_o : 1'b1),
      .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_oe ? miso_o : smiso), .miso_o(miso_o),
      .miso_oe_o(miso_oe), .select_n_i(sel_n));
   spi_slave_model slave (.sck_i(sck_oe ? sck_o : idle_clock_level), .sel_n_i(ssel_n), .mosi_i(mosi_o),
      .idle_clock_level_i(idle_clock_level), .capture_edge_choice_i(capture_edge_choice), .load_i(load), .miso_o(smiso), .got_o(sgot));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int half(input logic [2:0] c);
      case (c)
         3'b100: return 2;
         3'b000: return 4;
         3'b001: return 8;
         3'b110: return 16;
         3'b010: return 32;
         default: return 64;
      endcase
   endfunction : half
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Called at a rising edge; holds the request until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do
         @(posedge clk);
      while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(what, exp, q);
   endtask : rchk
   task automatic xfer(input logic [2:0] c, input logic clash);
      logic [7:0] d, q, cr;
      int e0;
      seed = lfsr(seed);
      d = seed[7:0];
      load <= seed[15:8];
      idle_clock_level <= seed[16];
      capture_edge_choice <= seed[17];
      cr = {2'b01, c[2], 1'b1, seed[16], seed[17], c[1:0]};
      bus(1'b1, CTRL_OFS, cr, q);
      rchk("ctrl", CTRL_OFS, cr);
      chk("owned", 8'h01, {7'h0, owned});
      ssel_n <= 1'b0;
      e0 = edges;
      bus(1'b1, DATA_OFS, d, q);
      if (clash)
         bus(1'b1, DATA_OFS, ~d, q);
      do
         bus(1'b0, FLAGS_OFS, 8'h00, q);
      while (q[DONE_BIT] !== 1'b1);
      chk("flags", {1'b1, clash, 6'h00}, q);
      bus(1'b1, DATA_OFS, ~d, q);
      repeat (40) @(posedge clk);
      chk("edges", 8'h10, 8'(edges - e0));
      chk("half", 8'(half(c)), 8'(last_gap));
      chk("idle", {7'h0, idle_clock_level}, {7'h0, sck_o});
      chk("slave rx", d, sgot);
      rchk("rx", DATA_OFS, load);
      rchk("cleared", FLAGS_OFS, 8'h00);
      ssel_n <= 1'b1;
   endtask : xfer
   always @(posedge clk)
   begin
      sck_q <= sck_o;
      gap <= (sck_o !== sck_q) ? 1 : gap + 1;
      if (sck_o !== sck_q)
      begin
         edges <= edges + 1;
         last_gap <= gap;
      end
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk("ctrl reset", CTRL_OFS, 8'h00);
      bus(1'b1, FLAGS_OFS, 8'hff, junk);
      rchk("flags ro", FLAGS_OFS, 8'h00);
      rchk("unmapped", 4'hc, 8'h00);
      for (int i = 0; i < 6; i++)
         xfer(codes[i], 1'b0);
      xfer(3'b000, 1'b1);
      gmask <= 1'b0;
      bus(1'b1, CTRL_OFS, 8'hd0, junk);
      sel_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk("irq", 8'h01, {7'h0, irq});
      rchk("fault", FLAGS_OFS, 8'h10);
      rchk("ctrl fault", CTRL_OFS, 8'h80);
      halt <= 1'b1;
      repeat (2) @(posedge clk);
      chk("wake halt", 8'h00, {7'h0, wake});
      halt <= 1'b0;
      repeat (2) @(posedge clk);
      chk("wake", 8'h01, {7'h0, wake});
      gmask <= 1'b1;
      repeat (2) @(posedge clk);
      chk("irq masked", 8'h00, {7'h0, irq});
      sel_n <= 1'b1;
      bus(1'b1, CTRL_OFS, 8'h80, junk);
      rchk("fault clear", FLAGS_OFS, 8'h00);
      gmask <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq off", 8'h00, {7'h0, irq});
      tally_and_finish();
   end
endmodule : tb_spi_ctrl
